/* cftd_pkg.sv */
// constants and types shared by the can frame trigger decoder
package cftd_pkg;
    // ------------------------------------------------------------
    // clocking and bit rate
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 200_000_000;
    localparam int MIN_BPS     = 1;
    localparam int MAX_BPS     = 1_000_000;
    localparam int PER_W       = 28;
    localparam int N_PRESET    = 10;
    localparam int PRESET_BPS [N_PRESET] = '{5_000, 10_000, 20_000, 50_000, 100_000,
                                             125_000, 250_000, 500_000, 800_000, 1_000_000};
    localparam int MIN_PER     = CLK_HZ / MAX_BPS;
    localparam int MAX_PER     = CLK_HZ / MIN_BPS;

    // ------------------------------------------------------------
    // frame layout, in destuffed bits
    // ------------------------------------------------------------
    localparam int STD_ID_LENGTH_SELECT = 11;
    localparam int EXT_ID_LENGTH_SELECT = 29;
    localparam int ARB_BITS    = 13;   // base id, rtr or srr, ide
    localparam int EXT_BITS    = 20;   // id extension, rtr, r1
    localparam int CTRL_BITS   = 5;    // r0 and length code
    localparam int CRC_BITS    = 15;
    localparam int TAIL_BITS   = 3;    // crc delimiter, ack slot, ack delimiter
    localparam int ACK_POS     = 1;
    localparam int EOF_BITS    = 7;
    localparam int STUFF_RUN   = 5;
    localparam int MAX_BYTES   = 8;
    localparam int BYTE_W      = 8;
    localparam int SLICE_CNT   = 4;
    localparam int TS_W        = 32;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        COND_START  = 3'h0,
        COND_REMOTE = 3'h1,
        COND_IDENT  = 3'h2,
        COND_IDENT_AND_PAYLOAD = 3'h3,
        COND_ERROR  = 3'h4
    } cftd_cond_t;

    typedef enum logic [1:0] {
        SRC_HIGH = 2'h0,
        SRC_LOW  = 2'h1,
        SRC_BOTH = 2'h2
    } cftd_src_t;

    typedef enum logic [2:0] {
        FLD_IDLE = 3'h0,
        FLD_ARB  = 3'h1,
        FLD_EXT  = 3'h2,
        FLD_CTRL = 3'h3,
        FLD_DATA = 3'h4,
        FLD_CRC  = 3'h5,
        FLD_TAIL = 3'h6,
        FLD_EOF  = 3'h7
    } cftd_fld_t;
endpackage : cftd_pkg

/* cftd_decoder.sv */
// can frame decoder with trigger conditions and a record fifo
// Functional notes
// - start condition fires at each frame start
// - remote condition: remote frames with matching id
// - id condition: data or remote, matching id
// - id plus first two bytes match
// - error condition fires on error frame
// - match uses 11-bit or 29-bit id
// - id written in byte slices, first lowest
// - preset rates 5k..1M or custom 1..1M
// - source is high, low or both lines
// - per-line threshold, also the trigger level
// - record flags data versus remote frame
// - id format detected, reported with length
// - record holds length, data, crc, ack
// - record holds time offset to trigger
// - fields separated: arbitration, control, data, crc
`timescale 1ns/1ps

// ------------------------------------------------------------
// record fifo
// ------------------------------------------------------------
module cftd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // fill side
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_r, wr_nxt, rd_r, rd_nxt, level;
    logic             push, pop;

    // pointers carry one extra bit so full and empty differ
    assign level     = wr_r - rd_r;
    assign in_ready  = level != (AW+1)'(DEPTH);
    assign out_valid = level != '0;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_r[AW-1:0]];

    // pointer next values
    always_comb begin
        wr_nxt = wr_r + (AW+1)'(push);
        rd_nxt = rd_r + (AW+1)'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else if (ce) begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // storage has no reset, only written entries are read
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end

    AST_FIFO_LEVEL: assert property (@(posedge clk) disable iff (rst)
        level <= (AW+1)'(DEPTH)) else $error("fifo level beyond depth");
endmodule : cftd_fifo

// ------------------------------------------------------------
// decoder top
// ------------------------------------------------------------
module cftd_decoder #(
    parameter int SAMP_W     = 8,
    parameter int FIFO_DEPTH = 32
) (
    // clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // sampled line levels and thresholds
    input  wire logic [SAMP_W-1:0] line_h_code,
    input  wire logic [SAMP_W-1:0] line_l_code,
    input  wire logic [SAMP_W-1:0] thr_h,
    input  wire logic [SAMP_W-1:0] thr_l,
    // configuration
    input  wire logic [1:0]        src_sel,
    input  wire logic              rate_custom,
    input  wire logic [3:0]        rate_preset,
    input  wire logic [19:0]       custom_bps,
    input  wire logic [2:0]        cond_sel,
    input  wire logic              id_length_select,
    input  wire logic [1:0]        id_slice_select,
    input  wire logic [7:0]        id_slice_data,
    input  wire logic              id_slice_we,
    input  wire logic [7:0]        match_byte_first,
    input  wire logic [7:0]        match_byte_second,
    // trigger and status
    output      logic              trig_pulse,
    output      logic              level_h,
    output      logic              level_l,
    output      logic [2:0]        cur_field,
    output      logic              rec_overflow,
    // frame records
    output      logic              rec_valid,
    input  wire logic              rec_ready,
    output      logic              rec_remote,
    output      logic              rec_ext,
    output      logic [28:0]       rec_id,
    output      logic [3:0]        rec_len,
    output      logic [63:0]       rec_data,
    output      logic [14:0]       rec_crc,
    output      logic              rec_ack,
    output      logic [31:0]       rec_time
);
    if (FIFO_DEPTH < 2 || SAMP_W < 1) begin : g_bad
        $error("bad decoder parameters");
    end
    localparam int REC_W = 1 + 1 + cftd_pkg::EXT_ID_LENGTH_SELECT + 4 + 64 + cftd_pkg::CRC_BITS
                           + 1 + cftd_pkg::TS_W;

    // id compare in the selected format
    function automatic logic id_hit(input logic [28:0] got, input logic ext,
                                    input logic [28:0] want, input logic want_ext);
        if (ext != want_ext) return 1'b0;
        if (ext) return got == want;
        return got[cftd_pkg::STD_ID_LENGTH_SELECT-1:0] == want[cftd_pkg::STD_ID_LENGTH_SELECT-1:0];
    endfunction : id_hit

    // ------------------------------------------------------------
    // line comparison, synchronisers, bit timing
    // ------------------------------------------------------------
    logic [2:0]                   hs_r, ls_r;
    logic                         lh_r, lh_nxt, ll_r, ll_nxt, bus_bit, prev_r;
    logic [cftd_pkg::PER_W-1:0]   per_r, per_nxt, cnt_r, cnt_nxt;
    logic                         bit_v;
    logic [31:0]                  bps;

    // comparators feed three flops; level moves once stages two and three agree
    always_comb begin
        lh_nxt = (hs_r[1] == hs_r[2]) ? hs_r[2] : lh_r;
        ll_nxt = (ls_r[1] == ls_r[2]) ? ls_r[2] : ll_r;
    end
    assign level_h = lh_r;
    assign level_l = ll_r;

    // 1 is recessive; high line is dominant when above, low line when below
    always_comb begin
        case (src_sel)
            cftd_pkg::SRC_HIGH: bus_bit = !lh_r;
            cftd_pkg::SRC_LOW:  bus_bit = ll_r;
            cftd_pkg::SRC_BOTH: bus_bit = !(lh_r && !ll_r);
            default:            bus_bit = !lh_r;
        endcase
    end

    // bit period from preset table or clamped custom rate
    always_comb begin
        if (rate_custom) begin
            bps = (custom_bps < 20'(cftd_pkg::MIN_BPS)) ? cftd_pkg::MIN_BPS :
                  (custom_bps > 20'(cftd_pkg::MAX_BPS)) ? cftd_pkg::MAX_BPS : 32'(custom_bps);
        end else if (rate_preset < 4'(cftd_pkg::N_PRESET)) begin
            bps = cftd_pkg::PRESET_BPS[rate_preset];
        end else begin
            bps = cftd_pkg::MAX_BPS;
        end
        per_nxt = cftd_pkg::PER_W'(cftd_pkg::CLK_HZ / bps);
    end

    // hard resync on each recessive to dominant edge, sample mid bit
    always_comb begin
        if (prev_r && !bus_bit) cnt_nxt = '0;
        else if (cnt_r >= per_r - 1'b1) cnt_nxt = '0;
        else cnt_nxt = cnt_r + 1'b1;
    end
    assign bit_v = ce && (cnt_r == (per_r >> 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_r   <= '0;
            ls_r   <= 3'h7; // idle low line is above threshold, no false edge after reset
            lh_r   <= 1'b0;
            ll_r   <= 1'b1;
            prev_r <= 1'b1;
            per_r  <= cftd_pkg::PER_W'(cftd_pkg::MIN_PER);
            cnt_r  <= '0;
        end else if (ce) begin
            hs_r   <= {hs_r[1:0], line_h_code > thr_h};
            ls_r   <= {ls_r[1:0], line_l_code > thr_l};
            lh_r   <= lh_nxt;
            ll_r   <= ll_nxt;
            prev_r <= bus_bit;
            per_r  <= per_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // trigger settings, id written slice by slice
    // ------------------------------------------------------------
    logic [28:0] idw_r, idw_nxt;

    always_comb begin
        idw_nxt = idw_r;
        for (int i = 0; i < cftd_pkg::SLICE_CNT; i++) begin
            if (id_slice_we && id_slice_select == 2'(i)) begin
                for (int b = 0; b < cftd_pkg::BYTE_W; b++) begin
                    if (i * cftd_pkg::BYTE_W + b < cftd_pkg::EXT_ID_LENGTH_SELECT) begin
                        idw_nxt[i * cftd_pkg::BYTE_W + b] = id_slice_data[b];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) idw_r <= '0;
        else if (ce) idw_r <= idw_nxt;
    end

    // ------------------------------------------------------------
    // field decoder and trigger
    // ------------------------------------------------------------
    cftd_pkg::cftd_fld_t st_r, st_nxt;
    logic [6:0]                 f_r, f_nxt;
    logic [2:0]                 same_r, same_nxt;
    logic                       last_r, last_nxt, rtr_r, rtr_nxt, ext_r, ext_nxt;
    logic                       hit_r, hit_nxt, ack_r, ack_nxt, trig_r, trig_nxt, push;
    logic [28:0]                id_r, id_nxt;
    logic [3:0]                 dlc_r, dlc_nxt;
    logic [63:0]                dat_r, dat_nxt;
    logic [14:0]                crc_r, crc_nxt;
    logic [cftd_pkg::TS_W-1:0]  ts_r, sof_r, sof_nxt, tt_r, tt_nxt;
    logic                       stuffed, use_bit, in_ready, ovf_r, ovf_nxt;
    logic [3:0]                 nby;
    logic [REC_W-1:0]           rec_in, rec_out;

    // stuffing covers start of frame up to the end of the crc field
    assign stuffed = st_r inside {cftd_pkg::FLD_ARB, cftd_pkg::FLD_EXT, cftd_pkg::FLD_CTRL,
                                  cftd_pkg::FLD_DATA, cftd_pkg::FLD_CRC};
    assign use_bit = bit_v && !(stuffed && same_r == 3'(cftd_pkg::STUFF_RUN));
    assign nby     = (rtr_r || dlc_r > 4'(cftd_pkg::MAX_BYTES)) ?
                     (rtr_r ? 4'h0 : 4'(cftd_pkg::MAX_BYTES)) : dlc_r;

    always_comb begin
        st_nxt = st_r;
        {f_nxt, same_nxt, last_nxt} = {f_r, same_r, last_r};
        {rtr_nxt, ext_nxt, hit_nxt, ack_nxt} = {rtr_r, ext_r, hit_r, ack_r};
        {id_nxt, dlc_nxt, dat_nxt, crc_nxt} = {id_r, dlc_r, dat_r, crc_r};
        {sof_nxt, tt_nxt} = {sof_r, tt_r};
        trig_nxt = 1'b0;
        push     = 1'b0;
        ovf_nxt  = ovf_r;
        if (bit_v) begin
            // run length for destuffing
            same_nxt = (bus_bit == last_r && same_r != 3'(cftd_pkg::STUFF_RUN)) ?
                       same_r + 3'h1 : 3'h1;
            last_nxt = bus_bit;
            if (stuffed && same_r == 3'(cftd_pkg::STUFF_RUN) && bus_bit == last_r) begin
                st_nxt   = cftd_pkg::FLD_EOF;
                f_nxt    = '0;
                trig_nxt = cond_sel == cftd_pkg::COND_ERROR;
            end
        end
        if (use_bit && st_nxt != cftd_pkg::FLD_EOF || use_bit && st_r == cftd_pkg::FLD_EOF) begin
            f_nxt = f_r + 7'h1;
            case (st_r)
                cftd_pkg::FLD_IDLE: begin
                    f_nxt = '0;
                    if (!bus_bit) begin
                        st_nxt   = cftd_pkg::FLD_ARB;
                        sof_nxt  = ts_r;
                        {id_nxt, dat_nxt, hit_nxt} = '0;
                        trig_nxt = cond_sel == cftd_pkg::COND_START;
                    end
                end
                cftd_pkg::FLD_ARB: begin
                    if (f_r < 7'(cftd_pkg::STD_ID_LENGTH_SELECT)) id_nxt = {id_r[27:0], bus_bit};
                    if (f_r == 7'(cftd_pkg::STD_ID_LENGTH_SELECT)) rtr_nxt = bus_bit;
                    if (f_r == 7'(cftd_pkg::ARB_BITS - 1)) begin
                        ext_nxt = bus_bit;
                        f_nxt   = '0;
                        st_nxt  = bus_bit ? cftd_pkg::FLD_EXT : cftd_pkg::FLD_CTRL;
                        if (!bus_bit) begin
                            hit_nxt  = id_hit(id_r, 1'b0, idw_r, id_length_select);
                            trig_nxt = hit_nxt && (cond_sel == cftd_pkg::COND_IDENT ||
                                       cond_sel == cftd_pkg::COND_REMOTE && rtr_r);
                        end
                    end
                end
                cftd_pkg::FLD_EXT: begin
                    if (f_r < 7'(cftd_pkg::EXT_BITS - 2)) id_nxt = {id_r[27:0], bus_bit};
                    if (f_r == 7'(cftd_pkg::EXT_BITS - 2)) begin
                        rtr_nxt  = bus_bit;
                        hit_nxt  = id_hit(id_r, 1'b1, idw_r, id_length_select);
                        trig_nxt = hit_nxt && (cond_sel == cftd_pkg::COND_IDENT ||
                                   cond_sel == cftd_pkg::COND_REMOTE && bus_bit);
                    end
                    if (f_r == 7'(cftd_pkg::EXT_BITS - 1)) begin
                        f_nxt  = '0;
                        st_nxt = cftd_pkg::FLD_CTRL;
                    end
                end
                cftd_pkg::FLD_CTRL: begin
                    if (f_r != '0) dlc_nxt = {dlc_r[2:0], bus_bit};
                    if (f_r == 7'(cftd_pkg::CTRL_BITS - 1)) begin
                        f_nxt  = '0;
                        st_nxt = (!rtr_r && {dlc_r[2:0], bus_bit} != 4'h0) ?
                                 cftd_pkg::FLD_DATA : cftd_pkg::FLD_CRC;
                    end
                end
                cftd_pkg::FLD_DATA: begin
                    dat_nxt = {dat_r[62:0], bus_bit};
                    if (f_r == 7'(2 * cftd_pkg::BYTE_W - 1)) begin
                        trig_nxt = cond_sel == cftd_pkg::COND_IDENT_AND_PAYLOAD && hit_r
                                   && dat_nxt[15:8] == match_byte_first
                                   && dat_nxt[7:0] == match_byte_second;
                    end
                    if (f_r == 7'(nby * cftd_pkg::BYTE_W) - 7'h1) begin
                        f_nxt  = '0;
                        st_nxt = cftd_pkg::FLD_CRC;
                    end
                end
                cftd_pkg::FLD_CRC: begin
                    crc_nxt = {crc_r[13:0], bus_bit};
                    if (f_r == 7'(cftd_pkg::CRC_BITS - 1)) begin
                        f_nxt  = '0;
                        st_nxt = cftd_pkg::FLD_TAIL;
                    end
                end
                cftd_pkg::FLD_TAIL: begin
                    if (f_r == 7'(cftd_pkg::ACK_POS)) ack_nxt = bus_bit;
                    if (f_r == 7'(cftd_pkg::TAIL_BITS - 1)) begin
                        f_nxt   = '0;
                        st_nxt  = cftd_pkg::FLD_EOF;
                        push    = 1'b1;
                        ovf_nxt = ovf_r || !in_ready;
                    end
                end
                cftd_pkg::FLD_EOF: begin
                    // leave only after a run of recessive bits
                    if (!bus_bit) f_nxt = '0;
                    else if (f_r == 7'(cftd_pkg::EOF_BITS - 1)) begin
                        f_nxt  = '0;
                        st_nxt = cftd_pkg::FLD_IDLE;
                    end
                end
                default: st_nxt = cftd_pkg::FLD_IDLE;
            endcase
        end
        if (trig_nxt) tt_nxt = ts_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= cftd_pkg::FLD_IDLE;
            {f_r, same_r, id_r, dlc_r, dat_r, crc_r} <= '0;
            {rtr_r, ext_r, hit_r, ack_r, trig_r, ovf_r} <= '0;
            last_r <= 1'b1;
            {ts_r, sof_r, tt_r} <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
            {f_r, same_r, last_r} <= {f_nxt, same_nxt, last_nxt};
            {rtr_r, ext_r, hit_r, ack_r} <= {rtr_nxt, ext_nxt, hit_nxt, ack_nxt};
            {id_r, dlc_r, dat_r, crc_r} <= {id_nxt, dlc_nxt, dat_nxt, crc_nxt};
            {sof_r, tt_r, ovf_r} <= {sof_nxt, tt_nxt, ovf_nxt};
            ts_r   <= ts_r + 1'b1;
            trig_r <= trig_nxt;
        end
    end

    assign trig_pulse   = trig_r;
    assign cur_field    = st_r;
    assign rec_overflow = ovf_r;

    // record: type, format, id, length, data, crc, ack, offset to trigger
    assign rec_in = {rtr_r, ext_r, id_r, dlc_r, dat_r, crc_r, ack_nxt, sof_r - tt_r};
    assign {rec_remote, rec_ext, rec_id, rec_len, rec_data, rec_crc, rec_ack, rec_time} = rec_out;

    // a full fifo drops the record and sets the sticky overflow flag
    cftd_fifo #(.WIDTH(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .in_valid (push),
        .in_ready (in_ready),
        .in_data  (rec_in),
        .out_valid(rec_valid),
        .out_ready(rec_ready),
        .out_data (rec_out)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_TRIG_PULSE: assert property (@(posedge clk) disable iff (rst)
        trig_pulse |=> !trig_pulse) else $error("trigger longer than one cycle");
    AST_START: assert property (@(posedge clk) disable iff (rst)
        (bit_v && st_r == cftd_pkg::FLD_IDLE && !bus_bit && cond_sel == cftd_pkg::COND_START)
        |=> trig_pulse && st_r == cftd_pkg::FLD_ARB) else $error("no start trigger");
    AST_REMOTE: assert property (@(posedge clk) disable iff (rst)
        trig_pulse && cond_sel == cftd_pkg::COND_REMOTE |-> rtr_r && hit_r)
        else $error("remote trigger on non-remote frame");
    AST_IDENT: assert property (@(posedge clk) disable iff (rst)
        trig_pulse && cond_sel == cftd_pkg::COND_IDENT |-> hit_r
        && st_r inside {cftd_pkg::FLD_CTRL, cftd_pkg::FLD_EXT})
        else $error("id trigger without id match");
    AST_PAYLOAD: assert property (@(posedge clk) disable iff (rst)
        trig_pulse && cond_sel == cftd_pkg::COND_IDENT_AND_PAYLOAD |-> hit_r && !rtr_r
        && dat_r[15:8] == match_byte_first && dat_r[7:0] == match_byte_second)
        else $error("payload trigger mismatch");
    AST_ERROR: assert property (@(posedge clk) disable iff (rst)
        trig_pulse && cond_sel == cftd_pkg::COND_ERROR |-> st_r == cftd_pkg::FLD_EOF)
        else $error("error trigger outside error state");
    AST_SLICE: assert property (@(posedge clk) disable iff (rst)
        ce && id_slice_we && id_slice_select == 2'h0 |=> idw_r[7:0] == $past(id_slice_data))
        else $error("first id slice not stored");
    AST_PERIOD: assert property (@(posedge clk) disable iff (rst)
        ##1 per_r >= cftd_pkg::PER_W'(cftd_pkg::MIN_PER)
        && per_r <= cftd_pkg::PER_W'(cftd_pkg::MAX_PER)) else $error("bit period out of range");
    AST_STUFF: assert property (@(posedge clk) disable iff (rst)
        bit_v && stuffed && same_r == 3'(cftd_pkg::STUFF_RUN) && bus_bit == last_r
        |=> st_r == cftd_pkg::FLD_EOF) else $error("stuff violation missed");
endmodule : cftd_decoder

/* cftd_can_model.sv */
// can bus model standing in for the bus of the device under test
`timescale 1ns/1ps
module cftd_can_model (
    // bus side
    input  wire logic       clk,
    output      logic [7:0] line_h_code,
    output      logic [7:0] line_l_code
);
    // bus rests recessive between frames
    initial begin
        line_h_code = 8'h80;
        line_l_code = 8'h80;
    end
    // one bit at 1 Mb/s, both lines kept complementary
    task automatic put(input logic b);
        line_h_code = b ? 8'h80 : 8'hc0;
        line_l_code = b ? 8'h80 : 8'h40;
        repeat (200) @(posedge clk);
        #1;
    endtask : put
    // stuffing only over the first ns bits, tail goes out raw
    task automatic send(input logic q [$], input int ns);
        int   run;
        logic lst;
        run = 0;
        lst = 1'b1;
        foreach (q[i]) begin
            if (i < ns && run == 5) begin
                put(!lst);
                lst = !lst;
                run = 1;
            end
            run = (q[i] == lst) ? run + 1 : 1;
            lst = q[i];
            put(lst);
        end
    endtask : send
endmodule : cftd_can_model

/* cftd_decoder_test.sv */
// self-checking bench for the can frame trigger decoder
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("mismatch %s exp %h got %h", n, e, a); end end
module cftd_decoder_test;
    logic        clk = 1'b0, rst = 1'b1, id_we = 1'b0, rec_ready = 1'b0;
    logic        ce = 1'b1, rate_cus = 1'b0, id_len = 1'b0, lvl_h, lvl_l, ovf;
    logic [19:0] bps_cus = 20'h0;
    logic [2:0]  fld;
    logic [31:0] rec_time;
    logic [1:0]  src = 2'h0, id_sel = 2'h0;
    logic [2:0]  cond = 3'h0;
    logic [7:0]  lh, ll, thr_h = 8'ha0, thr_l = 8'h60, id_dat = 8'h00, m1 = 8'h5a, m2 = 8'ha5;
    logic        trig_pulse, rec_valid, rec_remote, rec_ext, rec_ack;
    logic [28:0] rec_id;
    logic [3:0]  rec_len;
    logic [63:0] rec_data;
    logic [14:0] rec_crc;
    int          trig_n = 0, cyc = 0, err_total = 0, cmp_count = 0;
    cftd_can_model bus (.clk(clk), .line_h_code(lh), .line_l_code(ll));
    cftd_decoder #(.SAMP_W(8), .FIFO_DEPTH(32)) DUT (.clk(clk), .rst(rst), .ce(ce),
        .line_h_code(lh), .line_l_code(ll), .thr_h(thr_h), .thr_l(thr_l), .src_sel(src),
        .rate_custom(rate_cus), .rate_preset(4'h9), .custom_bps(bps_cus), .cond_sel(cond),
        .id_length_select(id_len), .id_slice_select(id_sel), .id_slice_data(id_dat),
        .id_slice_we(id_we), .match_byte_first(m1), .match_byte_second(m2),
        .trig_pulse(trig_pulse), .level_h(lvl_h), .level_l(lvl_l), .cur_field(fld),
        .rec_overflow(ovf),
        .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_remote(rec_remote),
        .rec_ext(rec_ext), .rec_id(rec_id), .rec_len(rec_len), .rec_data(rec_data),
        .rec_crc(rec_crc), .rec_ack(rec_ack), .rec_time(rec_time));
    always #2.5 clk = ~clk;
    // trigger pulses counted, hang cut short well past the expected run
    // counted mid cycle, away from the edge that launches the pulse
    always @(negedge clk) begin
        cyc++;
        if (trig_pulse === 1'b1) trig_n++;
        if (cyc == 95000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // one standard frame, length code 2, acked, then its record is popped
    task automatic frame(input int t, input logic [2:0] c, input logic [1:0] s,
                         input logic [10:0] id, input logic rtr, input logic [15:0] d,
                         input int et);
        logic [49:0] v;
        logic        q [$];
        int          tn;
        cond = c;
        src = s;
        tn = trig_n;
        v = {1'b0, id, rtr, 6'h02, d, 15'h2aaa};
        for (int i = 49; i >= 0; i--) if (!(rtr && i inside {[15:30]})) q.push_back(v[i]);
        tn = trig_n;
        for (int i = 0; i < 10; i++) q.push_back(i != 1); // ack slot driven dominant
        bus.send(q, q.size() - 10);
        `CHK("trig count", et, trig_n - tn)
        `CHK("rec_valid", 1'b1, rec_valid)
        `CHK("rec_id", {18'h0, id}, rec_id)
        `CHK("rec_remote", rtr, rec_remote)
        `CHK("rec_ext", 1'b0, rec_ext)
        `CHK("rec_len", 4'h2, rec_len)
        `CHK("rec_data", rtr ? 64'h0 : {48'h0, d}, rec_data)
        `CHK("rec_crc", 15'h2aaa, rec_crc)
        `CHK("rec_ack", 1'b0, rec_ack)
        `CHK("level_h", 1'b0, lvl_h)
        `CHK("level_l", 1'b1, lvl_l)
        `CHK("cur_field", 3'h0, fld)
        `CHK("rec_overflow", 1'b0, ovf)
        if (c == cftd_pkg::COND_START) `CHK("rec_time", 32'h0, rec_time)
        if (t == 2) `CHK("rec_time", 32'hfffff510, rec_time)
        rec_ready = 1'b1;
        @(posedge clk);
        #1;
        rec_ready = 1'b0;
        $display("test %0d done", t);
    endtask : frame
    // six dominant bits after the start bit break the stuff rule
    task automatic error_burst();
        logic q [$];
        int   tn;
        cond = cftd_pkg::COND_ERROR;
        tn = trig_n;
        for (int i = 0; i < 20; i++) q.push_back(i > 6);
        bus.send(q, 0);
        `CHK("trig count", 1, trig_n - tn)
        `CHK("rec_valid", 1'b0, rec_valid)
        $display("test 7 done");
    endtask : error_burst
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        id_we = 1'b1; // low slice first, then upper bits
        id_dat = 8'h13;
        @(posedge clk);
        #1;
        id_sel = 2'h1;
        id_dat = 8'h00;
        @(posedge clk);
        #1;
        id_we = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        frame(1, cftd_pkg::COND_START, cftd_pkg::SRC_HIGH, 11'h013, 1'b0, 16'h5aa5, 1);
        frame(2, cftd_pkg::COND_IDENT, cftd_pkg::SRC_LOW, 11'h013, 1'b1, 16'h0, 1);
        rate_cus = 1'b1;
        bps_cus = 20'hf4240;
        frame(3, cftd_pkg::COND_REMOTE, cftd_pkg::SRC_BOTH, 11'h013, 1'b0, 16'h5aa5, 0);
        bps_cus = 20'hfffff;
        frame(4, cftd_pkg::COND_REMOTE, cftd_pkg::SRC_BOTH, 11'h013, 1'b1, 16'h0, 1);
        frame(5, cftd_pkg::COND_IDENT_AND_PAYLOAD, 2'h2, 11'h013, 1'b0, 16'h5aa5, 1);
        frame(6, cftd_pkg::COND_IDENT_AND_PAYLOAD, 2'h2, 11'h013, 1'b0, 16'h5a00, 0);
        id_len = 1'b1;
        frame(8, cftd_pkg::COND_IDENT, cftd_pkg::SRC_HIGH, 11'h013, 1'b1, 16'h0, 0);
        id_len = 1'b0;
        error_burst();
        report_and_stop();
    end
endmodule : cftd_decoder_test
